/* src/pin_routing_params.svh */
// Purpose: Routing register offsets, resets and fields
// Assumes: Included by the design modules
// Notes: Definitions only
`ifndef PIN_ROUTING_PARAMS_SVH
`define PIN_ROUTING_PARAMS_SVH

// Register offsets
`define RT_ADDR_CLOCK_SOURCE 8'h11
`define RT_ADDR_DATA_SOURCE 8'h12
`define RT_ADDR_MIC_ROUTING 8'h13
`define RT_ADDR_PIN_ASSIGN 8'h14

// Reset values
`define RT_RST_CLOCK_SOURCE 8'h80
`define RT_RST_DATA_SOURCE 8'h00
`define RT_RST_MIC_ROUTING 8'h00
`define RT_RST_PIN_ASSIGN 8'h00

// Writable bits; reserved bits stay zero
`define RT_MASK_CLOCK_SOURCE 8'hFE
`define RT_MASK_DATA_SOURCE 8'hFC
`define RT_MASK_MIC_ROUTING 8'hFF
`define RT_MASK_PIN_ASSIGN 8'hFF

// Clock source fields
`define RT_PRI_IN_EN_BIT 7
`define RT_FS_HI 6
`define RT_FS_LO 4
`define RT_BCLK_HI 3
`define RT_BCLK_LO 1

// Data source fields
`define RT_SIN_HI 7
`define RT_SIN_LO 5
`define RT_SIN2_HI 4
`define RT_SIN2_LO 2

// Mic routing fields
`define RT_CH1_DIG_BIT 7
`define RT_CH2_DIG_BIT 6
`define RT_EDGE_A_BIT 5
`define RT_EDGE_B_BIT 4
`define RT_MIC_A_HI 3
`define RT_MIC_A_LO 2
`define RT_MIC_B_HI 1
`define RT_MIC_B_LO 0

// Pin assignment fields
`define RT_OVRD_BIT 7
`define RT_DOUT_DIN_BIT 6
`define RT_ADC_PD_HI 5
`define RT_ADC_PD_LO 4
`define RT_DAC_PD_HI 3
`define RT_DAC_PD_LO 2
`define RT_LIMITER_BIT 1
`define RT_AUX_AMP_BIT 0

// Data output pin function codes
`define RT_DOUT_FN_INPUT 4'h1
`define RT_DOUT_FN_PRIMARY_OUT 4'h5

`endif

/* src/pin_routing_pkg.sv */
// Purpose: Types shared by the routing modules
// Assumes: Codes as held in the selector fields
// Notes: Numbers live in pin_routing_params.svh
package pin_routing_pkg;
    typedef enum logic [2:0] {
        SRC_OFF = 3'h0,
        SRC_GP1 = 3'h1,
        SRC_GP2 = 3'h2,
        SRC_IP1 = 3'h3,
        SRC_DOUT = 3'h4,
        SRC_PRIMARY = 3'h5,
        SRC_RES6 = 3'h6,
        SRC_RES7 = 3'h7
    } src_code_t;

    typedef logic [7:0] reg_byte_t;
endpackage

/* src/route_if.sv */
// Purpose: Pins, codes and routed results between modules
// Assumes: One clock domain; plain levels
// Notes: Top drives pins and codes, the mux returns results
`timescale 1ns/1ps
`default_nettype none
interface route_if;
    logic gp1;
    logic gp2;
    logic ip1;
    logic dout_in;
    logic din;
    logic pfs;
    logic pbclk;
    logic [2:0] fs_code;
    logic [2:0] bclk_code;
    logic [2:0] in_code;
    logic [2:0] in2_code;
    logic [1:0] mic_a_code;
    logic [1:0] mic_b_code;
    logic [1:0] adc_code;
    logic [1:0] dac_code;
    logic mic_ovrd;
    logic fs;
    logic bclk;
    logic sin;
    logic sin2;
    logic mic_a;
    logic mic_b;
    logic adc_pin;
    logic dac_pin;
    logic sec_en;

    modport mux (
        input gp1, gp2, ip1, dout_in, din, pfs, pbclk,
        input fs_code, bclk_code, in_code, in2_code,
        input mic_a_code, mic_b_code, adc_code, dac_code, mic_ovrd,
        output fs, bclk, sin, sin2, mic_a, mic_b, adc_pin, dac_pin, sec_en
    );
    modport top (
        output gp1, gp2, ip1, dout_in, din, pfs, pbclk,
        output fs_code, bclk_code, in_code, in2_code,
        output mic_a_code, mic_b_code, adc_code, dac_code, mic_ovrd,
        input fs, bclk, sin, sin2, mic_a, mic_b, adc_pin, dac_pin, sec_en
    );
endinterface
`default_nettype wire

/* src/pin_source_mux.sv */
// Purpose: Pin selection for each routed function
// Assumes: Codes come straight from the registers
// Notes: Reserved codes route nothing and read low
`timescale 1ns/1ps
`default_nettype none
module pin_source_mux (
    route_if.mux bus
);
    import pin_routing_pkg::*;

    // Three-bit selector; caller gives codes 4 and 5
    function automatic logic pick3(input logic [2:0] code,
                                   input logic p, input logic q,
                                   input logic r, input logic c4,
                                   input logic c5);
        logic v;
        v = 1'b0;
        case (src_code_t'(code))
            SRC_GP1: v = p;
            SRC_GP2: v = q;
            SRC_IP1: v = r;
            SRC_DOUT: v = c4;
            SRC_PRIMARY: v = c5;
            default: v = 1'b0; // Off or reserved
        endcase
        return v;
    endfunction

    // Two-bit selector over the general pins and the third pin the caller gives
    function automatic logic pick2(input logic [1:0] code,
                                   input logic p, input logic q,
                                   input logic r);
        return pick3({1'b0, code}, p, q, r, 1'b0, 1'b0);
    endfunction

    // Port is on only when both clock selectors name a real source
    function automatic logic code_live(input logic [2:0] code);
        return (code != 3'h0) && (code != 3'h4) && (code <= 3'h5);
    endfunction

    logic mic_ip1;

    // Override swaps input pin one for the data input pin
    assign mic_ip1 = bus.mic_ovrd ? bus.din : bus.ip1;

    // Secondary port clocks, reserved code 4 refused
    assign bus.fs = pick3(bus.fs_code, bus.gp1, bus.gp2, bus.ip1,
                          1'b0, bus.pfs);
    assign bus.bclk = pick3(bus.bclk_code, bus.gp1, bus.gp2, bus.ip1,
                            1'b0, bus.pbclk);
    assign bus.sec_en = code_live(bus.fs_code) &
                        code_live(bus.bclk_code);

    // Secondary port data inputs
    assign bus.sin = pick3(bus.in_code, bus.gp1, bus.gp2, bus.ip1,
                           bus.dout_in, bus.din);
    assign bus.sin2 = pick3(bus.in2_code, bus.gp1, bus.gp2, bus.ip1,
                            bus.dout_in, bus.din);

    // Microphone data pins
    assign bus.mic_a = pick2(bus.mic_a_code, bus.gp1, bus.gp2,
                             mic_ip1);
    assign bus.mic_b = pick2(bus.mic_b_code, bus.gp1, bus.gp2,
                             mic_ip1);

    // Power-down request pins
    assign bus.adc_pin = pick2(bus.adc_code, bus.gp1, bus.gp2,
                               bus.ip1);
    assign bus.dac_pin = pick2(bus.dac_code, bus.gp1, bus.gp2,
                               bus.ip1);
endmodule // pin_source_mux
`default_nettype wire

/* src/audio_interface_pin_routing.sv */
// Purpose: Pin routing registers and registered routed outputs
// Assumes: Pins and control port synchronous to i_clock
// Notes: One cycle of delay on every routed signal
`timescale 1ns/1ps
`default_nettype none
`include "pin_routing_params.svh"
module audio_interface_pin_routing #(
    parameter int REG_WIDTH = 8
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire pin_routing_pkg::reg_byte_t i_wr_data,
    output logic [7:0] o_rd_data,

    input wire logic i_general_pin_one,
    input wire logic i_general_pin_two,
    input wire logic i_input_pin_one,
    input wire logic i_primary_data_in,
    input wire logic i_primary_frame_sync,
    input wire logic i_primary_bit_clock,
    input wire logic i_primary_data_out,
    input wire logic [3:0] i_dout_function,
    input wire logic i_dout_pin_in,
    input wire logic i_density_mod_clock,
    input wire logic i_adc_soft_power,
    input wire logic i_dac_soft_power,

    output logic o_dout_pin_out,
    output logic o_dout_pin_oe,
    output logic o_primary_input,
    output logic o_secondary_enable,
    output logic o_secondary_frame_sync,
    output logic o_secondary_bit_clock,
    output logic o_secondary_input,
    output logic o_secondary_input2,
    output logic o_record_ch1_digital_select,
    output logic o_record_ch2_digital_select,
    output logic [3:0] o_mic_samples,
    output logic o_adc_power_down,
    output logic o_dac_power_down,
    output logic o_power_limiter,
    output logic o_aux_amplifier
);
    import pin_routing_pkg::*;

    // Only byte registers are served
    if (REG_WIDTH != 8) begin : g_width_check
        $error("REG_WIDTH must be 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    reg_byte_t clock_source_r, clock_source_nxt;
    reg_byte_t data_source_r, data_source_nxt;
    reg_byte_t mic_routing_r, mic_routing_nxt;
    reg_byte_t pin_assign_r, pin_assign_nxt;

    logic [7:0] rd_data_nxt;

    // Masked writes keep reserved bits at zero
    always_comb begin
        clock_source_nxt = clock_source_r;
        data_source_nxt = data_source_r;
        mic_routing_nxt = mic_routing_r;
        pin_assign_nxt = pin_assign_r;
        if (i_wr_en) begin
            case (i_addr)
                `RT_ADDR_CLOCK_SOURCE: begin
                    clock_source_nxt = i_wr_data &
                        `RT_MASK_CLOCK_SOURCE;
                end

                `RT_ADDR_DATA_SOURCE: begin
                    data_source_nxt = i_wr_data &
                        `RT_MASK_DATA_SOURCE;
                end

                `RT_ADDR_MIC_ROUTING: begin
                    mic_routing_nxt = i_wr_data & `RT_MASK_MIC_ROUTING;
                end
                `RT_ADDR_PIN_ASSIGN: begin
                    pin_assign_nxt = i_wr_data & `RT_MASK_PIN_ASSIGN;
                end
                default: begin
                    clock_source_nxt = clock_source_r;
                end
            endcase
        end
    end

    // Read data, unmapped offsets read zero
    always_comb begin
        rd_data_nxt = o_rd_data;
        if (i_rd_en) begin
            case (i_addr)
                `RT_ADDR_CLOCK_SOURCE: rd_data_nxt = clock_source_r;
                `RT_ADDR_DATA_SOURCE: rd_data_nxt = data_source_r;
                `RT_ADDR_MIC_ROUTING: rd_data_nxt = mic_routing_r;
                `RT_ADDR_PIN_ASSIGN: rd_data_nxt = pin_assign_r;
                default: rd_data_nxt = 8'h00;
            endcase
        end
    end

    // Register file state
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            clock_source_r <= `RT_RST_CLOCK_SOURCE;
            data_source_r <= `RT_RST_DATA_SOURCE;
            mic_routing_r <= `RT_RST_MIC_ROUTING;
            pin_assign_r <= `RT_RST_PIN_ASSIGN;
            o_rd_data <= 8'h00;
        end else begin
            clock_source_r <= clock_source_nxt;
            data_source_r <= data_source_nxt;
            mic_routing_r <= mic_routing_nxt;
            pin_assign_r <= pin_assign_nxt;
            o_rd_data <= rd_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin selection

    route_if rt ();
    logic dout_is_input;
    logic dout_drives;

    // Data output pin mode: function code or dual use
    assign dout_is_input = (i_dout_function == `RT_DOUT_FN_INPUT) |
                           pin_assign_r[`RT_DOUT_DIN_BIT];
    assign dout_drives = (i_dout_function == `RT_DOUT_FN_PRIMARY_OUT);

    // Pins and codes toward the selector
    assign rt.gp1 = i_general_pin_one;
    assign rt.gp2 = i_general_pin_two;
    assign rt.ip1 = i_input_pin_one;
    assign rt.dout_in = dout_is_input & i_dout_pin_in;
    assign rt.din = i_primary_data_in;
    assign rt.pfs = i_primary_frame_sync;
    assign rt.pbclk = i_primary_bit_clock;

    assign rt.fs_code = clock_source_r[`RT_FS_HI:`RT_FS_LO];
    assign rt.bclk_code = clock_source_r[`RT_BCLK_HI:`RT_BCLK_LO];
    assign rt.in_code = data_source_r[`RT_SIN_HI:`RT_SIN_LO];
    assign rt.in2_code = data_source_r[`RT_SIN2_HI:`RT_SIN2_LO];
    assign rt.mic_a_code = mic_routing_r[`RT_MIC_A_HI:`RT_MIC_A_LO];
    assign rt.mic_b_code = mic_routing_r[`RT_MIC_B_HI:`RT_MIC_B_LO];
    assign rt.adc_code = pin_assign_r[`RT_ADC_PD_HI:`RT_ADC_PD_LO];
    assign rt.dac_code = pin_assign_r[`RT_DAC_PD_HI:`RT_DAC_PD_LO];
    assign rt.mic_ovrd = pin_assign_r[`RT_OVRD_BIT];

    pin_source_mux u_mux (
        .bus(rt.mux)
    );

    ////////////////////////////////////////////////////////////////////////
    // Digital microphone latching

    logic dmc_prev_r, dmc_prev_nxt;
    logic [3:0] mic_nxt;
    logic dmc_rise;
    logic dmc_fall;

    // Density clock edges at the system clock
    assign dmc_rise = i_density_mod_clock & ~dmc_prev_r;
    assign dmc_fall = ~i_density_mod_clock & dmc_prev_r;

    // First edge of a pair is the fall unless swapped
    function automatic logic latch_now(input logic swap, input logic first);
        return (swap ^ first) ? dmc_fall : dmc_rise;
    endfunction

    // Sample hold for four mic channels
    always_comb begin
        dmc_prev_nxt = i_density_mod_clock;
        mic_nxt = o_mic_samples;

        if (latch_now(mic_routing_r[`RT_EDGE_A_BIT], 1'b1)) begin
            mic_nxt[0] = rt.mic_a;
        end

        if (latch_now(mic_routing_r[`RT_EDGE_A_BIT], 1'b0)) begin
            mic_nxt[1] = rt.mic_a;
        end

        if (latch_now(mic_routing_r[`RT_EDGE_B_BIT], 1'b1)) begin
            mic_nxt[2] = rt.mic_b;
        end

        if (latch_now(mic_routing_r[`RT_EDGE_B_BIT], 1'b0)) begin
            mic_nxt[3] = rt.mic_b;
        end
    end

    // Microphone latch state
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            // Idle low, so release brings no false edge
            dmc_prev_r <= 1'b0;
            o_mic_samples <= 4'h0;
        end else begin
            dmc_prev_r <= dmc_prev_nxt;
            o_mic_samples <= mic_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered routed outputs

    logic dout_out_nxt, dout_oe_nxt, primary_in_nxt;
    logic sec_en_nxt, sec_fs_nxt, sec_bclk_nxt, sec_in_nxt, sec_in2_nxt;
    logic ch1_dig_nxt, ch2_dig_nxt;
    logic adc_pd_nxt, dac_pd_nxt, limiter_nxt, aux_amp_nxt;

    // Next values of every routed output
    always_comb begin
        dout_oe_nxt = dout_drives;
        dout_out_nxt = dout_drives & i_primary_data_out;

        primary_in_nxt = clock_source_r[`RT_PRI_IN_EN_BIT] &
                         i_primary_data_in;
        sec_en_nxt = rt.sec_en;
        sec_fs_nxt = rt.sec_en & rt.fs;
        sec_bclk_nxt = rt.sec_en & rt.bclk;
        sec_in_nxt = rt.sin;
        sec_in2_nxt = rt.sin2;

        ch1_dig_nxt = mic_routing_r[`RT_CH1_DIG_BIT];
        ch2_dig_nxt = mic_routing_r[`RT_CH2_DIG_BIT];

        adc_pd_nxt = rt.adc_pin | ~i_adc_soft_power;
        dac_pd_nxt = rt.dac_pin | ~i_dac_soft_power;
        limiter_nxt = pin_assign_r[`RT_LIMITER_BIT] &
                      i_general_pin_one;
        aux_amp_nxt = pin_assign_r[`RT_AUX_AMP_BIT] &
                      i_general_pin_one;
    end

    // Output flops
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            o_dout_pin_out <= 1'b0;
            o_dout_pin_oe <= 1'b0;
            o_primary_input <= 1'b0;
            o_secondary_enable <= 1'b0;
            o_secondary_frame_sync <= 1'b0;
            o_secondary_bit_clock <= 1'b0;
            o_secondary_input <= 1'b0;
            o_secondary_input2 <= 1'b0;
            o_record_ch1_digital_select <= 1'b0;
            o_record_ch2_digital_select <= 1'b0;
            // Converters start powered down
            o_adc_power_down <= 1'b1;
            o_dac_power_down <= 1'b1;
            o_power_limiter <= 1'b0;
            o_aux_amplifier <= 1'b0;
        end else begin
            o_dout_pin_out <= dout_out_nxt;
            o_dout_pin_oe <= dout_oe_nxt;
            o_primary_input <= primary_in_nxt;
            o_secondary_enable <= sec_en_nxt;
            o_secondary_frame_sync <= sec_fs_nxt;
            o_secondary_bit_clock <= sec_bclk_nxt;
            o_secondary_input <= sec_in_nxt;
            o_secondary_input2 <= sec_in2_nxt;
            o_record_ch1_digital_select <= ch1_dig_nxt;
            o_record_ch2_digital_select <= ch2_dig_nxt;
            o_adc_power_down <= adc_pd_nxt;
            o_dac_power_down <= dac_pd_nxt;
            o_power_limiter <= limiter_nxt;
            o_aux_amplifier <= aux_amp_nxt;
        end
    end
endmodule // audio_interface_pin_routing
`default_nettype wire

/* bench/audio_interface_pin_routing_monitor.sv */
// Purpose: Concurrent checks on the routing block ports
// Assumes: One clock, synchronous active-low reset
// Notes: Bound below
`timescale 1ns/1ps
`default_nettype none
module audio_interface_pin_routing_monitor (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire pin_routing_pkg::reg_byte_t i_wr_data,
    input wire logic [7:0] o_rd_data,
    input wire logic i_general_pin_one,
    input wire logic i_primary_data_in,
    input wire logic i_primary_data_out,
    input wire logic [3:0] i_dout_function,
    input wire logic i_adc_soft_power,
    input wire logic i_dac_soft_power,
    input wire logic o_dout_pin_out,
    input wire logic o_dout_pin_oe,
    input wire logic o_primary_input,
    input wire logic o_secondary_enable,
    input wire logic o_secondary_frame_sync,
    input wire logic o_secondary_bit_clock,
    input wire logic o_adc_power_down,
    input wire logic o_dac_power_down,
    input wire logic o_power_limiter,
    input wire logic o_aux_amplifier
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////////////
    // Write strobe followed at once by a read of the same place
    sequence s_wr_rd(logic [7:0] a);
        i_wr_en && !i_rd_en && i_addr == a ##1 i_rd_en && !i_wr_en && i_addr == a;
    endsequence
    a_pin_reg_rw: assert property (s_wr_rd(8'h14) |=> o_rd_data == $past(i_wr_data, 2))
        else $error("readback wrong");
    a_reserved_read_zero: assert property (i_rd_en && i_addr == 8'h11 |=> !o_rd_data[0])
        else $error("reserved bit set");
    a_unmapped_read_zero: assert property (i_rd_en && (i_addr < 8'h11 || i_addr > 8'h14) |=> o_rd_data == 8'h00)
        else $error("unmapped read");
    a_primary_gate: assert property (o_primary_input |-> $past(i_primary_data_in))
        else $error("primary input");
    a_sec_off_quiet: assert property (!o_secondary_enable |-> !o_secondary_frame_sync && !o_secondary_bit_clock)
        else $error("clocks while off");
    a_adc_soft_down: assert property (!i_adc_soft_power |=> o_adc_power_down)
        else $error("adc not down");
    a_dac_soft_down: assert property (!i_dac_soft_power |=> o_dac_power_down)
        else $error("dac not down");
    a_limiter_follows_pin: assert property (o_power_limiter |-> $past(i_general_pin_one))
        else $error("limiter");
    a_aux_follows_pin: assert property (o_aux_amplifier |-> $past(i_general_pin_one))
        else $error("aux amplifier");
    a_dout_drives_primary: assert property (i_dout_function == 4'h5 |=> o_dout_pin_oe && o_dout_pin_out == $past(i_primary_data_out))
        else $error("dout not driven");
    a_dout_released: assert property (i_dout_function == 4'h0 |=> !o_dout_pin_oe)
        else $error("dout driven while off");
endmodule // audio_interface_pin_routing_monitor
bind audio_interface_pin_routing audio_interface_pin_routing_monitor i_mon (.*);
`default_nettype wire

/* bench/mic_pair_model.sv */
// Purpose: Microphone pair on one density-modulated line
// Assumes: Clock and data change together at a rising edge
// Notes: Data is the hi level while the clock is high
`timescale 1ns/1ps
`default_nettype none
module mic_pair_model #(
    parameter int HALF = 4
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic i_hi_level,
    input wire logic i_lo_level,
    output logic o_mod_clock,
    output logic o_data
);
    int cnt;
    initial o_data = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Divider; idle data toggles so no stale level is seen
    always @(posedge i_clock) begin
        if (!i_nrst || !i_run) begin
            cnt <= 0;
            o_mod_clock <= 1'b0;
            o_data <= ~o_data;
        end else begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                o_mod_clock <= ~o_mod_clock;
                o_data <= o_mod_clock ? i_lo_level : i_hi_level;
            end
        end
    end
endmodule // mic_pair_model
`default_nettype wire

/* bench/audio_interface_pin_routing_tb.sv */
// Purpose: Register and routing scenarios
// Assumes: Inputs change by non-blocking assignment at edges
// Notes: Outputs checked two edges after a pin change
`timescale 1ns/1ps
`default_nettype none
module audio_interface_pin_routing_tb;
    import pin_routing_pkg::*;
    logic clock, nrst, wr_en, rd_en, gp1, gp2d, ip1, pdin_d, dout_in, pdout;
    logic pfs, pbclk, adc_soft, dac_soft, mic_run, en, pe;
    logic dout_o, dout_oe, prim_in, sec_en, sec_fs, sec_bclk, sin, sin2;
    logic ch1_dig, ch2_dig, adc_pd, dac_pd, lim, aux, mclk, a_data, b_data;
    logic [7:0] addr, rd_data;
    logic [4:0] p;
    logic [3:0] dfn, mic;
    logic [2:0] fsc;
    reg_byte_t wr_data;
    int fails, tests_run, cycles;
    audio_interface_pin_routing i_audio_interface_pin_routing (
        .i_clock(clock), .i_nrst(nrst), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wr_data(wr_data), .o_rd_data(rd_data),
        .i_general_pin_one(gp1), .i_general_pin_two(mic_run ? a_data : gp2d),
        .i_input_pin_one(ip1), .i_primary_data_in(mic_run ? b_data : pdin_d),
        .i_primary_frame_sync(pfs), .i_primary_bit_clock(pbclk),
        .i_primary_data_out(pdout), .i_dout_function(dfn),
        .i_dout_pin_in(dout_in), .i_density_mod_clock(mclk),
        .i_adc_soft_power(adc_soft), .i_dac_soft_power(dac_soft),
        .o_dout_pin_out(dout_o), .o_dout_pin_oe(dout_oe),
        .o_primary_input(prim_in), .o_secondary_enable(sec_en),
        .o_secondary_frame_sync(sec_fs), .o_secondary_bit_clock(sec_bclk),
        .o_secondary_input(sin), .o_secondary_input2(sin2),
        .o_record_ch1_digital_select(ch1_dig),
        .o_record_ch2_digital_select(ch2_dig), .o_mic_samples(mic),
        .o_adc_power_down(adc_pd), .o_dac_power_down(dac_pd),
        .o_power_limiter(lim), .o_aux_amplifier(aux));
    mic_pair_model i_mic_a (.i_clock(clock), .i_nrst(nrst), .i_run(mic_run),
        .i_hi_level(1'b1), .i_lo_level(1'b0), .o_mod_clock(mclk), .o_data(a_data));
    mic_pair_model i_mic_b (.i_clock(clock), .i_nrst(nrst), .i_run(mic_run),
        .i_hi_level(1'b0), .i_lo_level(1'b1), .o_mod_clock(), .o_data(b_data));
    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and shared tasks
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_byte(input string what, input reg_byte_t exp, input reg_byte_t got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input reg_byte_t d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // Read, after an optional back-to-back write
    task automatic rd(input logic [7:0] a, input reg_byte_t exp, input logic pre, input reg_byte_t d);
        @(posedge clock);
        wr_en <= pre;
        rd_en <= !pre;
        addr <= a;
        wr_data <= d;
        if (pre) begin
            @(posedge clock);
            wr_en <= 1'b0;
            rd_en <= 1'b1;
        end
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk_byte("read data", exp, rd_data);
    endtask
    task automatic pins(input logic [4:0] v);
        @(posedge clock);
        {gp1, gp2d, ip1, pdin_d, dout_in} <= v;
        {pfs, pbclk, pdout} <= {3{v[1]}};
        repeat (2) @(posedge clock);
        #1;
    endtask
    // Expected pin for a code under a walking pattern
    function automatic logic pick(input logic [2:0] c, input logic [4:0] v, input logic four);
        case (c)
            3'h1: pick = v[4];
            3'h2: pick = v[3];
            3'h3: pick = v[2];
            3'h4: pick = four & v[0];
            3'h5: pick = v[1];
            default: pick = 1'b0;
        endcase
    endfunction
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {nrst, wr_en, rd_en, gp1, gp2d, ip1, pdin_d, dout_in, pdout} = '0;
        {pfs, pbclk, mic_run, addr, wr_data, fails, tests_run, cycles} = '0;
        {adc_soft, dac_soft, dfn} = {2'b11, 4'h1};
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rd(8'h11, 8'h80, 1'b0, 8'h00);
        rd(8'h13, 8'h00, 1'b0, 8'h00);
        rd(8'h12, 8'hFC, 1'b1, 8'hFF);
        rd(8'h11, 8'hFE, 1'b1, 8'hFF);
        rd(8'h15, 8'h00, 1'b1, 8'hFF);
        rd(8'h10, 8'h00, 1'b0, 8'h00);
        rd(8'h14, 8'hA5, 1'b1, 8'hA5);
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 8; k++) begin
                fsc = (s != 0) ? 3'h1 : 3'(k);
                en = fsc inside {3'h1, 3'h2, 3'h3, 3'h5};
                wr(8'h11, {1'b1, fsc, fsc, 1'b0});
                wr(8'h12, {3'(k), 3'(k), 2'b00});
                for (int i = 0; i < 5; i++) begin
                    p = 5'h01 << i;
                    pins(p);
                    chk_bit("port enable", en, sec_en);
                    chk_bit("frame sync", pick(fsc, p, 1'b0), sec_fs);
                    chk_bit("bit clock", pick(fsc, p, 1'b0), sec_bclk);
                    chk_bit("primary in", p[1], prim_in);
                    if (s != 0) begin
                        chk_bit("data in", pick(3'(k), p, 1'b1), sin);
                        chk_bit("data in 2", pick(3'(k), p, 1'b1), sin2);
                    end
                end
            end
        end
        // Data output pin drive and dual use
        @(posedge clock) dfn <= 4'h5;
        pins(5'b00010);
        chk_bit("dout oe", 1'b1, dout_oe);
        chk_bit("dout level", 1'b1, dout_o);
        wr(8'h12, 8'h80);
        @(posedge clock) dfn <= 4'h0;
        pins(5'b00001);
        chk_bit("dout oe", 1'b0, dout_oe);
        chk_bit("dout as input", 1'b0, sin);
        wr(8'h14, 8'h40);
        pins(5'b00001);
        chk_bit("dout as input", 1'b1, sin);
        wr(8'h11, 8'h12);
        pins(5'b00010);
        chk_bit("primary off", 1'b0, prim_in);
        // Power-down, limiter, aux amplifier
        for (int c = 0; c < 4; c++) begin
            wr(8'h14, {2'b00, 2'(c), 2'(c), 2'(c)});
            for (int i = 2; i < 5; i++) begin
                p = 5'h01 << i;
                pins(p);
                pe = (c == 0) ? 1'b0 : p[5 - c];
                chk_bit("adc down", pe, adc_pd);
                chk_bit("dac down", pe, dac_pd);
                chk_bit("limiter", c[1] & p[4], lim);
                chk_bit("aux amp", c[0] & p[4], aux);
            end
        end
        {adc_soft, dac_soft} <= 2'b01;
        pins(5'b00000);
        chk_bit("adc soft", 1'b1, adc_pd);
        chk_bit("dac soft", 1'b0, dac_pd);
        {adc_soft, dac_soft} <= 2'b10;
        pins(5'b00000);
        chk_bit("dac soft", 1'b1, dac_pd);
        // Microphones: pair A on pin two, pair B via override
        wr(8'h14, 8'h80);
        wr(8'h13, 8'h9B);
        @(posedge clock) mic_run <= 1'b1;
        repeat (30) @(posedge clock);
        #1;
        chk_byte("mic", 8'h0A, {4'h0, mic});
        chk_bit("ch1 digital", 1'b1, ch1_dig);
        chk_bit("ch2 digital", 1'b0, ch2_dig);
        wr(8'h13, 8'h6B);
        repeat (30) @(posedge clock);
        #1;
        chk_byte("mic", 8'h05, {4'h0, mic});
        chk_bit("ch1 digital", 1'b0, ch1_dig);
        chk_bit("ch2 digital", 1'b1, ch2_dig);
        @(posedge clock) mic_run <= 1'b0;
        // Second reset in mid-run
        nrst <= 1'b0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rd(8'h13, 8'h00, 1'b0, 8'h00);
        rd(8'h11, 8'h80, 1'b0, 8'h00);
        tally_and_finish();
    end
endmodule // audio_interface_pin_routing_tb
`default_nettype wire
